/* src/slr_bank.sv */
// Serial link setup and monitoring threshold holding registers
`timescale 1ns/100ps
`default_nettype none

module slr_bank
    import slr_pkg::*;
#(
    parameter int TICK_CYCLES = TIMEOUT_TICK_CYCLES,
    parameter int UNIT_CYCLES = WAIT_UNIT_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic req_valid,
    input wire slr_req_t req,
    output logic rsp_valid,
    output slr_rsp_t rsp,
    input wire logic msg_received,
    output logic reply_go,
    output logic link_fault,
    output logic link_fault_pulse,
    input wire logic [7:0] thermal_load_pct,
    output logic thermal_warning_output,
    input wire logic [15:0] output_freq,
    output logic zero_speed_detect,
    input wire logic [7:0] heatsink_temp_c,
    output logic heatsink_overheat,
    input wire logic [3:0] trip_code,
    output logic alarm_code_enable,
    output logic [3:0] alarm_code_out,
    output slr_fmt_t link_fmt,
    output slr_span_t span_cal
);

    // Stored settings, one per holding register
    logic [15:0] thermal_warning_level;
    logic [15:0] alarm_code_output_mode;
    logic [15:0] zero_speed_level;
    logic [15:0] heatsink_warning_level;
    logic [15:0] link_speed_select;
    logic [15:0] node_address;
    logic [15:0] char_length_select;
    logic [15:0] parity_select;
    logic [15:0] stop_bits_select;
    logic [15:0] link_error_action;
    logic [15:0] link_timeout;
    logic [15:0] reply_wait_time;
    logic [15:0] protocol_select;
    logic [15:0] voltage_input_span;
    logic [15:0] current_input_span;
    logic [15:0] second_voltage_input_span;

    logic for_us;          // Request addressed to this node
    logic value_ok;        // Write value inside the accepted range
    logic do_write;        // Accepted write strobe
    logic [15:0] rd_value; // Read mux result
    logic [19:0] tick_cnt; // Cycles inside one 0.01 s tick
    logic [15:0] tick_num; // Elapsed ticks since last valid message
    logic expire;          // Timeout reached this cycle
    logic wait_busy;       // Reply wait running
    logic [19:0] unit_cnt; // Cycles inside one millisecond
    logic [15:0] units_left; // Milliseconds still to wait

    // Only our own node address is answered
    assign for_us = req_valid && (req.node == node_address[5:0]);

    // Range check per address; reserved and unknown addresses accept nothing
    always_comb begin
        unique case (req.addr)
            ADDR_THERMAL: value_ok = req.wdata <= MAX_THERMAL;
            ADDR_ALARM_MODE: value_ok = req.wdata <= MAX_ALARM_MODE;
            ADDR_ZERO_SPEED: value_ok = req.wdata <= MAX_ZERO_SPEED;
            ADDR_HEATSINK: value_ok = req.wdata <= MAX_HEATSINK;
            ADDR_LINK_SPEED: begin
                value_ok = req.wdata >= MIN_LINK_SPEED && req.wdata <= MAX_LINK_SPEED;
            end
            ADDR_NODE: value_ok = req.wdata >= MIN_NODE && req.wdata <= MAX_NODE;
            ADDR_CHAR_LEN: value_ok = req.wdata == CHAR_LEN_7 || req.wdata == CHAR_LEN_8;
            ADDR_PARITY: value_ok = req.wdata <= MAX_PARITY;
            ADDR_STOP_BITS: value_ok = req.wdata >= MIN_STOP && req.wdata <= MAX_STOP;
            ADDR_ERR_ACTION: value_ok = req.wdata <= MAX_ERR_ACTION;
            ADDR_TIMEOUT: value_ok = req.wdata <= MAX_TIMEOUT;
            ADDR_REPLY_WAIT: value_ok = req.wdata <= MAX_REPLY_WAIT;
            ADDR_PROTOCOL: value_ok = req.wdata <= MAX_PROTOCOL;
            ADDR_V_SPAN, ADDR_I_SPAN, ADDR_V2_SPAN: value_ok = req.wdata <= MAX_SPAN;
            default: value_ok = 1'b0;
        endcase
    end

    assign do_write = for_us && req.write && value_ok;

    // Read mux; reserved words read as zero
    always_comb begin
        unique case (req.addr)
            ADDR_THERMAL: rd_value = thermal_warning_level;
            ADDR_ALARM_MODE: rd_value = alarm_code_output_mode;
            ADDR_ZERO_SPEED: rd_value = zero_speed_level;
            ADDR_HEATSINK: rd_value = heatsink_warning_level;
            ADDR_LINK_SPEED: rd_value = link_speed_select;
            ADDR_NODE: rd_value = node_address;
            ADDR_CHAR_LEN: rd_value = char_length_select;
            ADDR_PARITY: rd_value = parity_select;
            ADDR_STOP_BITS: rd_value = stop_bits_select;
            ADDR_ERR_ACTION: rd_value = link_error_action;
            ADDR_TIMEOUT: rd_value = link_timeout;
            ADDR_REPLY_WAIT: rd_value = reply_wait_time;
            ADDR_PROTOCOL: rd_value = protocol_select;
            ADDR_V_SPAN: rd_value = voltage_input_span;
            ADDR_I_SPAN: rd_value = current_input_span;
            ADDR_V2_SPAN: rd_value = second_voltage_input_span;
            default: rd_value = 16'h0000;
        endcase
    end

    // Register writes; a rejected value leaves the old contents
    always_ff @(posedge mclk) begin
        if (srst) begin
            thermal_warning_level <= RST_THERMAL;
            alarm_code_output_mode <= RST_ALARM_MODE;
            zero_speed_level <= RST_ZERO_SPEED;
            heatsink_warning_level <= RST_HEATSINK;
            link_speed_select <= RST_LINK_SPEED;
            node_address <= RST_NODE;
            char_length_select <= RST_CHAR_LEN;
            parity_select <= RST_PARITY;
            stop_bits_select <= RST_STOP_BITS;
            link_error_action <= RST_ERR_ACTION;
            link_timeout <= RST_TIMEOUT;
            reply_wait_time <= RST_REPLY_WAIT;
            protocol_select <= RST_PROTOCOL;
            voltage_input_span <= RST_SPAN;
            current_input_span <= RST_SPAN;
            second_voltage_input_span <= RST_SPAN;
        end else if (do_write) begin
            unique case (req.addr)
                ADDR_THERMAL: thermal_warning_level <= req.wdata;
                ADDR_ALARM_MODE: alarm_code_output_mode <= req.wdata;
                ADDR_ZERO_SPEED: zero_speed_level <= req.wdata;
                ADDR_HEATSINK: heatsink_warning_level <= req.wdata;
                ADDR_LINK_SPEED: link_speed_select <= req.wdata;
                ADDR_NODE: node_address <= req.wdata;
                ADDR_CHAR_LEN: char_length_select <= req.wdata;
                ADDR_PARITY: parity_select <= req.wdata;
                ADDR_STOP_BITS: stop_bits_select <= req.wdata;
                ADDR_ERR_ACTION: link_error_action <= req.wdata;
                ADDR_TIMEOUT: link_timeout <= req.wdata;
                ADDR_REPLY_WAIT: reply_wait_time <= req.wdata;
                ADDR_PROTOCOL: protocol_select <= req.wdata;
                ADDR_V_SPAN: voltage_input_span <= req.wdata;
                ADDR_I_SPAN: current_input_span <= req.wdata;
                ADDR_V2_SPAN: second_voltage_input_span <= req.wdata;
                default: ; // Nothing stored at reserved words
            endcase
        end
    end

    // Answer one cycle after a request to our node
    always_ff @(posedge mclk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= for_us;
            if (for_us) begin
                rsp.rdata <= req.write ? 16'h0000 : rd_value;
                rsp.reject <= req.write && !value_ok;
            end
        end
    end

    // Monitoring comparators, registered so outputs are glitch free
    always_ff @(posedge mclk) begin
        if (srst) begin
            thermal_warning_output <= 1'b0;
            zero_speed_detect <= 1'b0;
            heatsink_overheat <= 1'b0;
        end else begin
            thermal_warning_output <= {8'h00, thermal_load_pct} >= thermal_warning_level;
            zero_speed_detect <= output_freq <= zero_speed_level;
            heatsink_overheat <= {8'h00, heatsink_temp_c} >= heatsink_warning_level;
        end
    end

    // Alarm code pins; 3-bit mode masks the top bit of the trip code
    always_ff @(posedge mclk) begin
        if (srst) begin
            alarm_code_enable <= 1'b0;
            alarm_code_out <= 4'h0;
        end else begin
            // Code zero means disabled, whatever the reset value happens to be
            alarm_code_enable <= alarm_code_output_mode != 16'h0000;
            unique case (alarm_code_output_mode)
                ALARM_MODE_3BIT: alarm_code_out <= {1'b0, trip_code[2:0]};
                ALARM_MODE_4BIT: alarm_code_out <= trip_code;
                default: alarm_code_out <= 4'h0;
            endcase
        end
    end

    // Character format and link settings for the link engine
    always_ff @(posedge mclk) begin
        if (srst) begin
            link_fmt <= '0;
        end else begin
            link_fmt.speed_code <= link_speed_select[2:0];
            link_fmt.test_mode <= link_speed_select == LINK_SPEED_TEST;
            link_fmt.eight_bits <= char_length_select == CHAR_LEN_8;
            link_fmt.parity_en <= parity_select != 16'h0000;
            link_fmt.parity_odd <= parity_select == PARITY_ODD;
            link_fmt.two_stop <= stop_bits_select == MAX_STOP;
            link_fmt.modbus_rtu <= protocol_select[0];
            link_fmt.node <= node_address[5:0];
            link_fmt.error_action <= link_error_action[2:0];
        end
    end

    // Span calibration straight from the registers
    assign span_cal = '{voltage: voltage_input_span, current: current_input_span,
                        voltage2: second_voltage_input_span};

    // Timeout tick counter; restarts on every valid message, idle while zero
    always_ff @(posedge mclk) begin
        if (srst || msg_received || link_timeout == 16'h0000 || link_fault) begin
            tick_cnt <= 20'h00000;
            tick_num <= 16'h0000;
        end else if (tick_cnt == 20'(TICK_CYCLES - 1)) begin
            tick_cnt <= 20'h00000;
            tick_num <= tick_num + 16'h0001;
        end else begin
            tick_cnt <= tick_cnt + 20'h00001;
        end
    end

    assign expire = link_timeout != 16'h0000 && tick_num == link_timeout && !link_fault;

    // Fault latch; expiry wins over a clearing message in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            link_fault <= 1'b0;
            link_fault_pulse <= 1'b0;
        end else begin
            link_fault_pulse <= expire;
            if (expire) begin
                link_fault <= 1'b1;
            end else if (msg_received) begin
                link_fault <= 1'b0;
            end
        end
    end

    // Reply wait; a new message restarts the wait
    always_ff @(posedge mclk) begin
        if (srst) begin
            wait_busy <= 1'b0;
            unit_cnt <= 20'h00000;
            units_left <= 16'h0000;
            reply_go <= 1'b0;
        end else if (msg_received) begin
            wait_busy <= 1'b1;
            unit_cnt <= 20'h00000;
            units_left <= reply_wait_time;
            reply_go <= 1'b0;
        end else if (wait_busy && units_left == 16'h0000) begin
            wait_busy <= 1'b0;
            reply_go <= 1'b1;
        end else if (wait_busy && unit_cnt == 20'(UNIT_CYCLES - 1)) begin
            unit_cnt <= 20'h00000;
            units_left <= units_left - 16'h0001;
            reply_go <= 1'b0;
        end else begin
            unit_cnt <= wait_busy ? unit_cnt + 20'h00001 : 20'h00000;
            reply_go <= 1'b0;
        end
    end

    // Checks next to the logic
    sequence s_bad_write;
        for_us && req.write && !value_ok;
    endsequence

    a_reject_flag: assert property (@(posedge mclk) disable iff (srst)
        s_bad_write |=> rsp_valid && rsp.reject)
        else $error("Out of range write not rejected");

    a_old_value_kept: assert property (@(posedge mclk) disable iff (srst)
        s_bad_write ##0 req.addr == ADDR_THERMAL |=> $stable(thermal_warning_level))
        else $error("Rejected write changed thermal level");

    a_node_filter: assert property (@(posedge mclk) disable iff (srst)
        req_valid && req.node != node_address[5:0] |=> !rsp_valid)
        else $error("Answered a foreign node");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
        for_us && !req.write && req.addr == 16'h1454 |=> rsp.rdata == 16'h0000)
        else $error("Reserved word read not zero");

    a_char_len_legal: assert property (@(posedge mclk) disable iff (srst)
        char_length_select == CHAR_LEN_7 || char_length_select == CHAR_LEN_8)
        else $error("Character length illegal");

    a_thermal_out: assert property (@(posedge mclk) disable iff (srst)
        {8'h00, thermal_load_pct} >= thermal_warning_level ##1 !$past(srst)
        |-> thermal_warning_output)
        else $error("Thermal warning missed");

    a_alarm_3bit: assert property (@(posedge mclk) disable iff (srst)
        alarm_code_output_mode == ALARM_MODE_3BIT |=> !alarm_code_out[3])
        else $error("Top alarm bit set in 3-bit mode");

    a_zero_wait: assert property (@(posedge mclk) disable iff (srst)
        msg_received && reply_wait_time == 16'h0000 ##1 !msg_received
        |=> reply_go)
        else $error("Zero wait reply late");

    a_no_early_reply: assert property (@(posedge mclk) disable iff (srst)
        msg_received && reply_wait_time != 16'h0000 |=> !reply_go [*2])
        else $error("Reply before wait elapsed");

    a_fault_latch: assert property (@(posedge mclk) disable iff (srst)
        expire |=> link_fault && link_fault_pulse ##1 !link_fault_pulse)
        else $error("Timeout did not trip");

endmodule // slr_bank

`default_nettype wire

/* src/slr_pkg.sv */
// Constants and carrier types for the serial link and threshold register bank
package slr_pkg;

    // Holding register word addresses
    localparam logic [15:0] ADDR_THERMAL = 16'h1441;
    localparam logic [15:0] ADDR_ALARM_MODE = 16'h1442;
    localparam logic [15:0] ADDR_ZERO_SPEED = 16'h1443;
    localparam logic [15:0] ADDR_HEATSINK = 16'h1444;
    localparam logic [15:0] ADDR_LINK_SPEED = 16'h144b;
    localparam logic [15:0] ADDR_NODE = 16'h144c;
    localparam logic [15:0] ADDR_CHAR_LEN = 16'h144d;
    localparam logic [15:0] ADDR_PARITY = 16'h144e;
    localparam logic [15:0] ADDR_STOP_BITS = 16'h144f;
    localparam logic [15:0] ADDR_ERR_ACTION = 16'h1450;
    localparam logic [15:0] ADDR_TIMEOUT = 16'h1451;
    localparam logic [15:0] ADDR_REPLY_WAIT = 16'h1452;
    localparam logic [15:0] ADDR_PROTOCOL = 16'h1453;
    localparam logic [15:0] ADDR_V_SPAN = 16'h1455;
    localparam logic [15:0] ADDR_I_SPAN = 16'h1456;
    localparam logic [15:0] ADDR_V2_SPAN = 16'h1457;

    // Accepted value limits
    localparam logic [15:0] MAX_THERMAL = 16'h0064;     // 100 %
    localparam logic [15:0] MAX_ALARM_MODE = 16'h0002;
    localparam logic [15:0] MAX_ZERO_SPEED = 16'h2710;  // 10000 x 0.01 Hz
    localparam logic [15:0] MAX_HEATSINK = 16'h00c8;    // 200 degC
    localparam logic [15:0] MIN_LINK_SPEED = 16'h0002;
    localparam logic [15:0] MAX_LINK_SPEED = 16'h0006;
    localparam logic [15:0] MIN_NODE = 16'h0001;
    localparam logic [15:0] MAX_NODE = 16'h0020;        // 32
    localparam logic [15:0] CHAR_LEN_7 = 16'h0007;
    localparam logic [15:0] CHAR_LEN_8 = 16'h0008;
    localparam logic [15:0] MAX_PARITY = 16'h0002;
    localparam logic [15:0] MIN_STOP = 16'h0001;
    localparam logic [15:0] MAX_STOP = 16'h0002;
    localparam logic [15:0] MAX_ERR_ACTION = 16'h0004;
    localparam logic [15:0] MAX_TIMEOUT = 16'h270f;     // 9999 x 0.01 s
    localparam logic [15:0] MAX_REPLY_WAIT = 16'h03e8;  // 1000 ms
    localparam logic [15:0] MAX_PROTOCOL = 16'h0001;
    localparam logic [15:0] MAX_SPAN = 16'hfffa;        // 65530

    // Code values
    localparam logic [15:0] ALARM_MODE_3BIT = 16'h0001;
    localparam logic [15:0] ALARM_MODE_4BIT = 16'h0002;
    localparam logic [15:0] PARITY_EVEN = 16'h0001;
    localparam logic [15:0] PARITY_ODD = 16'h0002;
    localparam logic [15:0] LINK_SPEED_TEST = 16'h0002;

    // Values after reset
    localparam logic [15:0] RST_THERMAL = 16'h0050;
    localparam logic [15:0] RST_ALARM_MODE = 16'h0000;
    localparam logic [15:0] RST_ZERO_SPEED = 16'h0000;
    localparam logic [15:0] RST_HEATSINK = 16'h0078;
    localparam logic [15:0] RST_LINK_SPEED = 16'h0004;
    localparam logic [15:0] RST_NODE = 16'h0001;
    localparam logic [15:0] RST_CHAR_LEN = 16'h0007;
    localparam logic [15:0] RST_PARITY = 16'h0001;
    localparam logic [15:0] RST_STOP_BITS = 16'h0001;
    localparam logic [15:0] RST_ERR_ACTION = 16'h0002;
    localparam logic [15:0] RST_TIMEOUT = 16'h0000;
    localparam logic [15:0] RST_REPLY_WAIT = 16'h0000;
    localparam logic [15:0] RST_PROTOCOL = 16'h0000;
    localparam logic [15:0] RST_SPAN = 16'h0000;

    // Timing: clock period, timeout tick and reply wait unit
    localparam int CLK_PERIOD_NS = 25;
    localparam int TIMEOUT_TICK_NS = 10000000;          // 0.01 s
    localparam int WAIT_UNIT_NS = 1000000;              // 1 ms
    localparam int TIMEOUT_TICK_CYCLES = TIMEOUT_TICK_NS / CLK_PERIOD_NS;
    localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;

    // Register request from the network front end
    typedef struct packed {
        logic [5:0] node;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } slr_req_t;

    // Register answer
    typedef struct packed {
        logic [15:0] rdata;
        logic reject;
    } slr_rsp_t;

    // Serial character and link settings for the link engine
    typedef struct packed {
        logic [2:0] speed_code;
        logic test_mode;
        logic eight_bits;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic modbus_rtu;
        logic [5:0] node;
        logic [2:0] error_action;
    } slr_fmt_t;

    // Analog span calibration values
    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [15:0] voltage2;
    } slr_span_t;

endpackage

/* sim/slr_master.sv */
// Network master model that issues register requests to the bank
`timescale 1ns/100ps
`default_nettype none
module slr_master
    import slr_pkg::*;
(
    input wire logic mclk,
    input wire logic rsp_valid,
    input wire slr_rsp_t rsp,
    output logic req_valid,
    output slr_req_t req
);
    // Idle at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // One request; got is low when no answer came one cycle later
    task automatic xfer(input logic [5:0] nd, input logic wr, input logic [15:0] a,
            input logic [15:0] d, output logic got, output slr_rsp_t r);
        @(negedge mclk);
        req_valid = 1'b1;
        req = '{node: nd, write: wr, addr: a, wdata: d};
        @(negedge mclk);
        req_valid = 1'b0;
        // Released lines show the inverse, never the stale request
        req = ~req;
        got = rsp_valid;
        r = rsp;
    endtask
endmodule // slr_master
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the serial link and threshold register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import slr_pkg::*;
    logic mclk, srst, req_valid, rsp_valid, msg_received, reply_go, link_fault, link_fault_pulse;
    slr_req_t req;
    slr_rsp_t rsp;
    logic [7:0] thermal_load_pct, heatsink_temp_c;
    logic [15:0] output_freq;
    logic [3:0] trip_code, alarm_code_out;
    logic thermal_warning_output, zero_speed_detect, heatsink_overheat, alarm_code_enable;
    slr_fmt_t link_fmt;
    slr_span_t span_cal;
    int miscompares = 0, checks_done = 0, cyc = 0;
    logic [5:0] nd = 6'h01; // Node the master currently addresses
    // Register map: address, value after reset, largest accepted value
    logic [15:0] ta[16] = '{16'h1441, 16'h1442, 16'h1443, 16'h1444, 16'h144b, 16'h144c,
        16'h144d, 16'h144e, 16'h144f, 16'h1450, 16'h1451, 16'h1452, 16'h1453, 16'h1455,
        16'h1456, 16'h1457};
    logic [15:0] tr[16] = '{16'h0050, 16'h0000, 16'h0000, 16'h0078, 16'h0004, 16'h0001,
        16'h0007, 16'h0001, 16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};
    logic [15:0] tm[16] = '{16'h0064, 16'h0002, 16'h2710, 16'h00c8, 16'h0006, 16'h0020,
        16'h0008, 16'h0002, 16'h0002, 16'h0004, 16'h270f, 16'h03e8, 16'h0001, 16'hfffa,
        16'hfffa, 16'hfffa};
    // Short counts keep timeout and wait runs brief
    slr_bank #(.TICK_CYCLES(4), .UNIT_CYCLES(3)) dut (.mclk(mclk), .srst(srst),
        .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
        .msg_received(msg_received), .reply_go(reply_go), .link_fault(link_fault),
        .link_fault_pulse(link_fault_pulse), .thermal_load_pct(thermal_load_pct),
        .thermal_warning_output(thermal_warning_output), .output_freq(output_freq),
        .zero_speed_detect(zero_speed_detect), .heatsink_temp_c(heatsink_temp_c),
        .heatsink_overheat(heatsink_overheat), .trip_code(trip_code),
        .alarm_code_enable(alarm_code_enable), .alarm_code_out(alarm_code_out),
        .link_fmt(link_fmt), .span_cal(span_cal));
    slr_master m (.mclk(mclk), .rsp_valid(rsp_valid), .rsp(rsp), .req_valid(req_valid),
        .req(req));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Single value comparison
    task automatic chk(input string nm, input logic [47:0] g, input logic [47:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic rj);
        logic g;
        slr_rsp_t r;
        m.xfer(nd, 1'b1, a, d, g, r);
        chk("write answer", {46'h0, g, r.reject}, {46'h0, 1'b1, rj});
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        logic g;
        slr_rsp_t r;
        m.xfer(nd, 1'b0, a, 16'h0000, g, r);
        chk("read answer", {31'h0, g, r.rdata}, {31'h0, 1'b1, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 16; i++) rd(ta[i], tr[i]);
        chk("fmt reset", 48'(link_fmt), 48'({3'h4, 4'b0010, 2'b00, 6'h01, 3'h2}));
    endtask
    task automatic t_ranges;
        logic g;
        slr_rsp_t r;
        logic [15:0] la[4] = '{16'h144b, 16'h144c, 16'h144d, 16'h144f};
        logic [15:0] ld[4] = '{16'h0001, 16'h0000, 16'h0006, 16'h0000};
        logic [15:0] lm[4] = '{16'h0006, 16'h0020, 16'h0008, 16'h0002};
        for (int i = 0; i < 16; i++) begin
            wr(ta[i], tm[i], 1'b0);
            if (ta[i] == ADDR_NODE) nd = 6'h20;
            rd(ta[i], tm[i]);
            wr(ta[i], tm[i] + 16'h0001, 1'b1);
            rd(ta[i], tm[i]);
        end
        chk("fmt max", 48'(link_fmt), 48'({3'h6, 6'b011111, 6'h20, 3'h4}));
        chk("spans", 48'(span_cal), {3{16'hfffa}});
        for (int i = 0; i < 4; i++) begin
            wr(la[i], ld[i], 1'b1);
            rd(la[i], lm[i]);
        end
        m.xfer(6'h01, 1'b0, ADDR_NODE, 16'h0000, g, r);
        chk("other node", {47'h0, g}, 48'h0);
        wr(ADDR_NODE, 16'h0001, 1'b0);
        nd = 6'h01;
        wr(ADDR_LINK_SPEED, LINK_SPEED_TEST, 1'b0);
        tick(1);
        chk("test mode", {44'h0, link_fmt.speed_code, link_fmt.test_mode}, 48'h5);
    endtask
    task automatic t_reserved;
        logic [15:0] ra[6] = '{16'h143f, 16'h1440, 16'h1445, 16'h144a, 16'h1454, 16'h1458};
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], 16'h0001, 1'b1);
            rd(ra[i], 16'h0000);
        end
    endtask
    task automatic t_monitors;
        logic [3:0] ex[3] = '{4'h0, 4'h3, 4'hb};
        wr(ADDR_THERMAL, 16'h0032, 1'b0);
        wr(ADDR_HEATSINK, MAX_HEATSINK, 1'b0);
        wr(ADDR_ZERO_SPEED, MAX_ZERO_SPEED, 1'b0);
        thermal_load_pct = 8'h32;
        heatsink_temp_c = 8'hc8;
        output_freq = 16'h2710;
        tick(3);
        chk("monitors on", {thermal_warning_output, heatsink_overheat, zero_speed_detect},
            48'h7);
        thermal_load_pct = 8'h31;
        heatsink_temp_c = 8'hc7;
        output_freq = 16'h2711;
        tick(3);
        chk("monitors off", {thermal_warning_output, heatsink_overheat, zero_speed_detect},
            48'h0);
        trip_code = 4'hb;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_ALARM_MODE, 16'(i), 1'b0);
            tick(2);
            chk("alarm code", {alarm_code_enable, alarm_code_out}, {i != 0, ex[i]});
        end
    endtask
    // Pulse a message arrival and count cycles until sig rises
    task automatic msg_wait(ref logic sig, output int n);
        msg_received = 1'b1;
        tick(1);
        msg_received = 1'b0;
        n = 1;
        while (sig !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_timeout;
        int n;
        wr(ADDR_TIMEOUT, 16'h0002, 1'b0);
        msg_wait(link_fault, n);
        chk("timeout span", 48'(n >= 10 && n <= 12), 48'h1);
        chk("fault pulse", {47'h0, link_fault_pulse}, 48'h1);
        tick(1);
        chk("fault held", {link_fault, link_fault_pulse}, 48'h2);
        msg_received = 1'b1;
        tick(1);
        msg_received = 1'b0;
        wr(ADDR_TIMEOUT, 16'h0000, 1'b0);
        tick(30);
        chk("fault cleared", {47'h0, link_fault}, 48'h0);
    endtask
    task automatic t_reply;
        int n;
        wr(ADDR_REPLY_WAIT, 16'h0000, 1'b0);
        msg_wait(reply_go, n);
        chk("reply no wait", 48'(n), 48'd2);
        wr(ADDR_REPLY_WAIT, 16'h0002, 1'b0);
        msg_wait(reply_go, n);
        chk("reply wait", 48'(n >= 8 && n <= 10), 48'h1);
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        msg_received = 1'b0;
        thermal_load_pct = 8'h00;
        heatsink_temp_c = 8'h00;
        output_freq = 16'h0000;
        trip_code = 4'h0;
        tick(4);
        srst = 1'b0;
        t_reset();
        t_ranges();
        t_reserved();
        t_monitors();
        t_timeout();
        t_reply();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
